/* File: ebev_chipset.sv */
// Chipset-side model for stop-clock, probe, recovery and ignore lines
`timescale 1ns/1ps
`default_nettype none
module ebev_chipset (
  input wire logic i_shutdown_req,
  output logic o_stop_n,
  output logic o_probe_n,
  output logic o_recov_n,
  output logic o_restart_n,
  output logic o_ignore_n,
  output logic o_nmi
);
  // ==========================================
  // Shutdown turned into an external error
  assign o_nmi = i_shutdown_req;
  initial begin
    o_stop_n = 1'b1;
    o_probe_n = 1'b1;
    o_recov_n = 1'b1;
    o_restart_n = 1'b1;
    o_ignore_n = 1'b1;
  end
  // Levels change only off the clock edge and stay until the next call
  task drive(input logic [4:0] v);
    {o_stop_n, o_probe_n, o_recov_n, o_restart_n, o_ignore_n} = v;
  endtask
endmodule
`default_nettype wire

/* File: ebev_pkg.sv */
// Package with shared constants for the error and break event block
package ebev_pkg;
  // ==========================================================
  // Reset values
  localparam logic EBEV_FP_ERR_RST = 1'b0;
  localparam logic EBEV_BREAK_RST = 1'b0;
  localparam logic EBEV_INTERNAL_ERROR_OUT_RST = 1'b0;
  localparam logic [1:0] EBEV_SYNC_RST = 2'h0;
  // ==========================================================
  // Synchroniser depth
  localparam int EBEV_SYNC_STAGES = 2;
  // ==========================================================
  // Multiplexed output mode
  typedef enum logic {EBEV_MODE_FPERR, EBEV_MODE_BREAK} ebev_mode_t;
endpackage

/* File: ebev_sync.sv */
// Two-stage level synchroniser
`timescale 1ns/1ps
`default_nettype none
module ebev_sync (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  ebev_sync_if.dst sync_bus
);
  logic [1:0] stage_reg;
  // ==========================================================
  // Synchroniser
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stage_reg <= ebev_pkg::EBEV_SYNC_RST;
    end else begin
      stage_reg <= {stage_reg[0], sync_bus.async_level}; // [RULE12]
    end
  end
  assign sync_bus.sync_level = stage_reg[1];
endmodule
`default_nettype wire

/* File: ebev_sync_if.sv */
// Interface carrying the synchronised ignore-numeric-fault level
`timescale 1ns/1ps
`default_nettype none
interface ebev_sync_if;
  logic async_level;
  logic sync_level;
  modport src (output async_level, input sync_level);
  modport dst (input async_level, output sync_level);
endinterface
`default_nettype wire

/* File: ebev_top.sv */
// Error and break event signalling logic of the processor
// Function
// RULE1: Stop-clock off: assert multiplexed output on unmasked floating-point error.
// RULE2: Stop-clock on: multiplexed output signals a pending break event.
// RULE3: Break indication holds until stop-clock request deasserts.
// RULE4: Debug probe request during stop-clock counts as a break event.
// RULE5: Internal error asserts internal-error output, with shutdown request.
// RULE6: Internal-error output holds until reset, bus recovery or soft restart.
// RULE7: System may convert shutdown into an external error such as NMI.
// RULE8: Ignore-numeric-fault asserted: pending numeric error is ignored.
// RULE9: Ignore deasserted: non-control FP instruction faults on earlier error.
// RULE10: Native numeric-error mode bit makes the ignore input ineffective.
// RULE11: System holds ignore input valid by target-ready of the I/O write.
// RULE12: Ignore input synchronised by two flops; error outputs active low.
`timescale 1ns/1ps
`default_nettype none
module ebev_top (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_stop_clock_request_n,
  input wire logic i_debug_probe_request_n,
  input wire logic i_fp_error_unmasked,
  input wire logic i_break_event,
  input wire logic i_internal_error,
  input wire logic i_bus_recovery_in_n,
  input wire logic i_soft_restart_n,
  input wire logic i_ignore_numeric_fault_in_n,
  input wire logic i_native_numeric_error_mode,
  input wire logic i_fp_noncontrol_issue,
  output logic o_fp_error_break_event_out_n,
  output logic o_internal_error_out_n,
  output logic o_shutdown_req,
  output logic o_fp_exception,
  output logic o_fp_error_pending
);
  ebev_sync_if sync_bus ();
  logic fp_err_reg;
  logic break_reg;
  logic internal_error_out_reg;
  logic pend_reg;
  logic shut_reg;
  logic exc_reg;
  logic ign_sync;
  logic ignore_eff;
  logic stopclk;
  ebev_pkg::ebev_mode_t mode;

  // ==========================================================
  // Synchronise ignore input
  assign sync_bus.async_level = ~i_ignore_numeric_fault_in_n;
  ebev_sync u_sync (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .sync_bus(sync_bus)
  );
  assign ign_sync = sync_bus.sync_level; // [RULE12]
  assign ignore_eff = ign_sync && !i_native_numeric_error_mode; // [RULE10]
  assign stopclk = ~i_stop_clock_request_n;
  assign mode = stopclk ? ebev_pkg::EBEV_MODE_BREAK : ebev_pkg::EBEV_MODE_FPERR;

  // ==========================================================
  // Floating-point error indication
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fp_err_reg <= ebev_pkg::EBEV_FP_ERR_RST;
    end else begin
      fp_err_reg <= i_fp_error_unmasked; // [RULE1]
    end
  end

  // ==========================================================
  // Pending break indication
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      break_reg <= ebev_pkg::EBEV_BREAK_RST;
    end else if (!stopclk) begin
      break_reg <= 1'b0; // [RULE3]
    end else if (i_break_event || !i_debug_probe_request_n) begin
      break_reg <= 1'b1; // [RULE2] [RULE4]
    end
  end

  always_comb begin
    case (mode)
      ebev_pkg::EBEV_MODE_FPERR: o_fp_error_break_event_out_n = ~fp_err_reg; // [RULE1]
      ebev_pkg::EBEV_MODE_BREAK: o_fp_error_break_event_out_n = ~break_reg; // [RULE2]
      default: o_fp_error_break_event_out_n = 1'b1;
    endcase
  end

  // ==========================================================
  // Internal error and shutdown
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      internal_error_out_reg <= ebev_pkg::EBEV_INTERNAL_ERROR_OUT_RST;
    end else if (i_internal_error) begin
      internal_error_out_reg <= 1'b1; // [RULE5]
    end else if (!i_bus_recovery_in_n || !i_soft_restart_n) begin
      internal_error_out_reg <= 1'b0; // [RULE6]
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      shut_reg <= 1'b0;
    end else begin
      shut_reg <= i_internal_error && !internal_error_out_reg; // [RULE5]
    end
  end
  assign o_internal_error_out_n = ~internal_error_out_reg; // [RULE12]
  assign o_shutdown_req = shut_reg;

  // ==========================================================
  // Numeric error pending and exception
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_reg <= 1'b0;
    end else if (i_fp_error_unmasked) begin
      pend_reg <= 1'b1;
    end else if (i_fp_noncontrol_issue && !ignore_eff) begin
      pend_reg <= 1'b0; // [RULE9]
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      exc_reg <= 1'b0;
    end else begin
      exc_reg <= i_fp_noncontrol_issue && pend_reg && !ignore_eff; // [RULE8] [RULE9]
    end
  end
  assign o_fp_exception = exc_reg;
  assign o_fp_error_pending = pend_reg;

  // ==========================================================
  // Checks
  property p_fp_report;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (i_fp_error_unmasked && stopclk == 1'b0) ##1 !stopclk |-> !o_fp_error_break_event_out_n;
  endproperty
  a_fp_report: assert property (p_fp_report) else $error("fp error not reported"); // [RULE1]

  property p_break_set;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (stopclk && i_break_event) ##1 stopclk |-> !o_fp_error_break_event_out_n;
  endproperty
  a_break_set: assert property (p_break_set) else $error("break not reported"); // [RULE2]

  sequence s_break_shown;
    stopclk && !o_fp_error_break_event_out_n;
  endsequence
  property p_break_hold;
    @(posedge i_core_clk) disable iff (!i_resetn)
      s_break_shown ##1 stopclk |-> !o_fp_error_break_event_out_n;
  endproperty
  a_break_hold: assert property (p_break_hold) else $error("break dropped early"); // [RULE3]

  property p_probe;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (stopclk && !i_debug_probe_request_n) ##1 stopclk |-> !o_fp_error_break_event_out_n;
  endproperty
  a_probe: assert property (p_probe) else $error("probe not a break event"); // [RULE4]

  property p_internal_error_out_set;
    @(posedge i_core_clk) disable iff (!i_resetn)
      i_internal_error |=> !o_internal_error_out_n;
  endproperty
  a_internal_error_out_set: assert property (p_internal_error_out_set) else $error("internal error not shown"); // [RULE5]

  property p_internal_error_out_hold;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (!o_internal_error_out_n && i_bus_recovery_in_n && i_soft_restart_n)
        |=> !o_internal_error_out_n;
  endproperty
  a_internal_error_out_hold: assert property (p_internal_error_out_hold) else $error("internal error dropped"); // [RULE6]

  property p_ignore;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (ignore_eff && i_fp_noncontrol_issue) |=> !o_fp_exception;
  endproperty
  a_ignore: assert property (p_ignore) else $error("exception while ignoring"); // [RULE8]

  property p_raise;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (pend_reg && i_fp_noncontrol_issue && i_native_numeric_error_mode) |=> o_fp_exception;
  endproperty
  a_raise: assert property (p_raise) else $error("exception missing"); // [RULE9] [RULE10]

  property p_sync;
    @(posedge i_core_clk) disable iff (!i_resetn)
      !i_ignore_numeric_fault_in_n [*3] |-> ign_sync;
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser delay wrong"); // [RULE12]

  sequence s_internal_error_out_first;
    i_internal_error && o_internal_error_out_n;
  endsequence
  property p_shut_first;
    @(posedge i_core_clk) disable iff (!i_resetn)
      s_internal_error_out_first |=> o_shutdown_req;
  endproperty
  a_shut_first: assert property (p_shut_first) else $error("shutdown missing"); // [RULE5]

  property p_shut_pulse;
    @(posedge i_core_clk) disable iff (!i_resetn)
      o_shutdown_req |=> !o_shutdown_req;
  endproperty
  a_shut_pulse: assert property (p_shut_pulse) else $error("shutdown too long"); // [RULE5]

  property p_internal_error_out_clear;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (!i_internal_error && (!i_bus_recovery_in_n || !i_soft_restart_n))
        |=> o_internal_error_out_n;
  endproperty
  a_internal_error_out_clear: assert property (p_internal_error_out_clear) else $error("internal error kept"); // [RULE6]

  property p_fp_idle;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (!stopclk && !i_fp_error_unmasked) ##1 !stopclk |-> o_fp_error_break_event_out_n;
  endproperty
  a_fp_idle: assert property (p_fp_idle) else $error("output low while idle"); // [RULE1] [RULE2]

  property p_pend_set;
    @(posedge i_core_clk) disable iff (!i_resetn)
      i_fp_error_unmasked |=> o_fp_error_pending;
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("error not pending"); // [RULE9]

  sequence s_exc_due;
    pend_reg && i_fp_noncontrol_issue && !ignore_eff && !i_fp_error_unmasked;
  endsequence
  property p_exc_clear;
    @(posedge i_core_clk) disable iff (!i_resetn)
      s_exc_due |=> (o_fp_exception && !o_fp_error_pending);
  endproperty
  a_exc_clear: assert property (p_exc_clear) else $error("exception missed"); // [RULE9]

  property p_ignore_keep;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (ignore_eff && pend_reg) |=> o_fp_error_pending;
  endproperty
  a_ignore_keep: assert property (p_ignore_keep) else $error("pending error lost"); // [RULE8]
endmodule
`default_nettype wire

/* File: ebev_top_tb.sv */
// Testbench for the error and break event block
`timescale 1ns/1ps
`default_nettype none
module ebev_top_tb;
  logic clk = 1'b0;
  logic rst_n;
  logic fpe;
  logic brk;
  logic internal_error_out;
  logic nat;
  logic iss;
  logic stop_n, probe_n, recov_n, rest_n, ign_n, nmi;
  logic feb_n, internal_error_out_n, shut, exc, pend;
  int error_cnt = 0;
  int check_count = 0;
  // ==========================================
  // Clock, design and partner
  always #2.5 clk = ~clk;
  ebev_top DUT (.i_core_clk(clk), .i_resetn(rst_n), .i_stop_clock_request_n(stop_n),
    .i_debug_probe_request_n(probe_n), .i_fp_error_unmasked(fpe), .i_break_event(brk),
    .i_internal_error(internal_error_out), .i_bus_recovery_in_n(recov_n), .i_soft_restart_n(rest_n),
    .i_ignore_numeric_fault_in_n(ign_n), .i_native_numeric_error_mode(nat),
    .i_fp_noncontrol_issue(iss), .o_fp_error_break_event_out_n(feb_n),
    .o_internal_error_out_n(internal_error_out_n), .o_shutdown_req(shut), .o_fp_exception(exc),
    .o_fp_error_pending(pend));
  ebev_chipset PEER (.i_shutdown_req(shut), .o_stop_n(stop_n), .o_probe_n(probe_n),
    .o_recov_n(recov_n), .o_restart_n(rest_n), .o_ignore_n(ign_n), .o_nmi(nmi));
  // ==========================================
  // Helpers
  task chk(input logic got, input logic exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task wrap_up;
    if (error_cnt == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task t_fp;
    fpe = 1'b1;
    brk = 1'b1;
    cyc(2);
    chk(feb_n, 1'b0, "fp error not shown");
    fpe = 1'b0;
    cyc(2);
    chk(feb_n, 1'b1, "break shown while running");
    brk = 1'b0;
  endtask
  task t_brk;
    PEER.drive(5'h0f);
    cyc(2);
    chk(feb_n, 1'b1, "break with no event");
    brk = 1'b1;
    cyc(1);
    brk = 1'b0;
    chk(feb_n, 1'b0, "break not shown");
    cyc(5);
    chk(feb_n, 1'b0, "break dropped");
    PEER.drive(5'h1f);
    cyc(1);
    chk(feb_n, 1'b1, "break kept");
    PEER.drive(5'h17);
    cyc(2);
    chk(feb_n, 1'b1, "probe shown while running");
    PEER.drive(5'h07);
    cyc(2);
    chk(feb_n, 1'b0, "probe not shown");
    PEER.drive(5'h1f);
    cyc(2);
  endtask
  task t_internal_error_out;
    for (int k = 0; k < 3; k++) begin
      internal_error_out = 1'b1;
      cyc(1);
      internal_error_out = 1'b0;
      chk(internal_error_out_n, 1'b0, "internal error not shown");
      chk(shut, 1'b1, "no shutdown");
      chk(nmi, 1'b1, "no external error");
      cyc(4);
      chk(internal_error_out_n, 1'b0, "internal error dropped");
      chk(shut, 1'b0, "shutdown too long");
      internal_error_out = 1'b1;
      cyc(1);
      internal_error_out = 1'b0;
      chk(shut, 1'b0, "shutdown repeated");
      if (k == 2) begin
        rst_n = 1'b0;
      end else begin
        PEER.drive(k ? 5'h1d : 5'h1b);
      end
      cyc(1);
      chk(internal_error_out_n, 1'b1, "internal error kept");
      rst_n = 1'b1;
      PEER.drive(5'h1f);
      cyc(1);
    end
  endtask
  task t_ign;
    for (int k = 0; k < 3; k++) begin
      nat = (k == 2);
      PEER.drive(k == 1 ? 5'h1f : 5'h1e);
      fpe = 1'b1;
      cyc(1);
      fpe = 1'b0;
      chk(pend, 1'b1, "error not pending");
      cyc(3);
      iss = 1'b1;
      cyc(1);
      iss = 1'b0;
      chk(exc, k != 0, "wrong exception");
      chk(pend, k == 0, "wrong pending state");
    end
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    rst_n = 1'b0;
    fpe = 1'b0;
    brk = 1'b0;
    internal_error_out = 1'b0;
    nat = 1'b0;
    iss = 1'b0;
    cyc(20);
    rst_n = 1'b1;
    cyc(1);
    chk(feb_n, 1'b1, "idle level");
    chk(internal_error_out_n, 1'b1, "idle level");
    t_fp;
    t_brk;
    t_internal_error_out;
    t_ign;
    wrap_up;
  end
  initial begin
    #2000;
    error_cnt++;
    wrap_up;
  end
endmodule
`default_nettype wire
